//--- hdl/sar_adc_control_unit.sv
// Functional notes
// R1: conversion is 2 set-up, 6 sample, 2 per bit: 28 conversion clocks.
// R2: at completion load result, set done flag, raise interrupt.
// R3: done flag reads zero while a conversion runs.
// R4: done flag cleared by enable written zero or stop mode; read-only.
// R5: enable bit gates the module; stop mode disables it.
// R6: writing one to start bit triggers a conversion; zero does nothing.
// R7: trigger select: zero software start, one timer compare-A strobe.
// R8: alignment zero msb-aligned in high byte; one lsb-aligned in low byte.
// R9: clock select 00..11 gives 1, 0.5, 0.25, 0.125 MHz.
// R10: channel codes 0 to 10 select eleven analog inputs.
// R11: reference select zero internal supply, one external pin.
// R12: interrupt flag set by event, cleared by writing zero or acknowledge.
// R13: software configures, polls done flag, then reads both result bytes.
// R14: result bytes hold old value until completion; undefined after reset.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_unit
  import sar_adc_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [sar_adc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [sar_adc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      stop_mode,
  input  wire logic                      timer_match,
  input  wire logic                      int_ack,
  input  wire logic                      comp_in,
  output sar_adc_pkg::core_ctrl_t        core_ctrl,
  output logic                           irq
);
  import sar_adc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] div_limit(input logic [1:0] sel);
    div_limit = 9'(DIV_BASE << sel);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic              aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0]        wbyte_r, wbyte_nxt;
  logic              wstrb0_r, wstrb0_nxt;
  logic              awready_r, awready_nxt, wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              en_r, en_nxt, ref_r, ref_nxt, done_r, done_nxt;
  logic [3:0]        chan_r, chan_nxt;
  logic              intf_r, intf_nxt, trigger_source_select_r, trigger_source_select_nxt, align_r, align_nxt;
  logic [1:0]        conversion_clock_select_r, conversion_clock_select_nxt;
  logic              stat_r, stat_nxt, mask_r, mask_nxt, irq_r, irq_nxt;
  conv_state_t       st_r, st_nxt;
  logic [8:0]        div_r, div_nxt;
  logic [4:0]        cnt_r, cnt_nxt;
  logic [3:0]        bit_r, bit_nxt;
  logic              ph_r, ph_nxt;
  logic [9:0]        sar_r, sar_nxt;
  logic [7:0]        res_hi_r, res_hi_nxt, res_lo_r, res_lo_nxt;
  core_ctrl_t        core_r, core_nxt;
  logic              comp_m_r, comp_s_r;
  logic              wr_fire, wr_ok, wr_lo, wr_hi, wr_st, wr_mk, ar_fire;
  logic              eff_en, tick, start, finish, sw_start, trigger;
  logic [9:0]        final_res;
  logic [31:0]       rd_mux;
  logic              rd_ok;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_ok   = wr_fire & wstrb0_r;
  assign wr_lo   = wr_ok & hit(awaddr_r, A_CTRL_LOW);
  assign wr_hi   = wr_ok & hit(awaddr_r, A_CTRL_HIGH);
  assign wr_st   = wr_ok & hit(awaddr_r, A_IRQ_STAT);
  assign wr_mk   = wr_ok & hit(awaddr_r, A_IRQ_MASK);
  assign ar_fire = s_axi_arvalid & arready_r;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      A_CTRL_LOW:  rd_mux[7:0] = {en_r, 1'b0, ref_r, done_r, chan_r};
      A_CTRL_HIGH: rd_mux[7:0] = {intf_r, 3'h0, trigger_source_select_r, align_r, conversion_clock_select_r};
      A_RES_LOW:   rd_mux[7:0] = res_lo_r;
      A_RES_HIGH:  rd_mux[7:0] = res_hi_r;
      A_IRQ_STAT:  rd_mux[0]   = stat_r;
      A_IRQ_MASK:  rd_mux[0]   = mask_r;
      default:     rd_ok       = 1'b0;
    endcase
  end

  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wbyte_nxt   = wbyte_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (hit(awaddr_r, A_CTRL_LOW) | hit(awaddr_r, A_CTRL_HIGH) |
                     hit(awaddr_r, A_RES_LOW) | hit(awaddr_r, A_RES_HIGH) |
                     hit(awaddr_r, A_IRQ_STAT) | hit(awaddr_r, A_IRQ_MASK)) ? RESP_OK : RESP_ERR;
    end else if (bvalid_r & s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_awvalid & awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid & wready_r) begin
      w_held_nxt = 1'b1;
      wbyte_nxt  = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (ar_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_mux;
      rresp_nxt  = rd_ok ? RESP_OK : RESP_ERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = ~aw_held_nxt;
    wready_nxt  = ~w_held_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  // stop mode comes from the same clock; comparator is analog and needs syncing
  assign eff_en    = en_r & ~stop_mode;
  assign tick      = (st_r != ST_IDLE) & (div_r == div_limit(conversion_clock_select_r) - 9'h1);
  // R6: start bit pulse
  assign sw_start  = wr_lo & wbyte_r[B_START];
  // R7: trigger source mux
  assign trigger   = trigger_source_select_r ? timer_match : sw_start;
  assign start     = eff_en & (st_r == ST_IDLE) & trigger;
  assign finish    = tick & (st_r == ST_CONVERT) & ph_r & (bit_r == 4'h0);
  assign final_res = {sar_r[9:1], comp_s_r};

  always_comb begin
    st_nxt     = st_r;
    div_nxt    = tick ? 9'h0 : div_r + 9'h1;
    cnt_nxt    = cnt_r;
    bit_nxt    = bit_r;
    ph_nxt     = ph_r;
    sar_nxt    = sar_r;
    res_hi_nxt = res_hi_r;
    res_lo_nxt = res_lo_r;
    done_nxt   = done_r;
    if (start) begin
      st_nxt   = ST_SETUP;
      div_nxt  = 9'h0;
      cnt_nxt  = 5'h0;
      // R3: busy reads zero
      done_nxt = 1'b0;
    end else if (tick) begin
      cnt_nxt = cnt_r + 5'h1;
      // R1: 2 + 6 + 2 x 10 ticks
      unique case (st_r)
        ST_SETUP: if (cnt_r == SETUP_TICKS - 5'h1) begin
          st_nxt  = ST_SAMPLE;
          cnt_nxt = 5'h0;
        end
        ST_SAMPLE: if (cnt_r == SAMPLE_TICKS - 5'h1) begin
          st_nxt  = ST_CONVERT;
          bit_nxt = MSB_INDEX;
          ph_nxt  = 1'b0;
          sar_nxt = 10'h0;
        end
        ST_CONVERT: begin
          ph_nxt = ~ph_r;
          if (!ph_r) begin
            sar_nxt[bit_r] = 1'b1;
          end else begin
            sar_nxt[bit_r] = comp_s_r;
            bit_nxt        = bit_r - 4'h1;
          end
          if (finish) begin
            st_nxt = ST_IDLE;
            // R2: load result and flag done
            done_nxt = 1'b1;
            // R8: alignment at load
            // R14: update only here
            if (align_r) begin
              res_hi_nxt = {6'h0, final_res[9:8]};
              res_lo_nxt = final_res[7:0];
            end else begin
              res_hi_nxt = final_res[9:2];
              res_lo_nxt = {final_res[1:0], 6'h0};
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
    // R4: disable clears done
    // R5: disable aborts
    if (!eff_en || (wr_lo && !wbyte_r[B_ENABLE])) begin
      st_nxt   = ST_IDLE;
      done_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // control registers and interrupt
  // ----------------------------------------
  always_comb begin
    en_nxt    = wr_lo ? wbyte_r[B_ENABLE] : en_r;
    // R11: reference select
    ref_nxt   = wr_lo ? wbyte_r[B_REF] : ref_r;
    // R10: channel select, 0..10 valid
    chan_nxt  = wr_lo ? wbyte_r[3:0] : chan_r;
    trigger_source_select_nxt  = wr_hi ? wbyte_r[B_TRIGGER_SOURCE_SELECT] : trigger_source_select_r;
    align_nxt = wr_hi ? wbyte_r[B_ALIGN] : align_r;
    // R9: divider code
    conversion_clock_select_nxt = wr_hi ? wbyte_r[1:0] : conversion_clock_select_r;
    // R12: set wins over clears
    intf_nxt  = finish | (intf_r & ~(wr_hi & ~wbyte_r[B_INTF]) & ~int_ack);
    stat_nxt  = finish | (stat_r & ~(wr_st & wbyte_r[B_EVT]));
    mask_nxt  = wr_mk ? wbyte_r[B_EVT] : mask_r;
    irq_nxt   = stat_nxt & mask_nxt;
    core_nxt.enable  = eff_en;
    core_nxt.ref_ext = ref_nxt;
    core_nxt.channel = chan_nxt;
    core_nxt.sample  = (st_nxt == ST_SAMPLE);
    core_nxt.trial   = sar_nxt;
  end

  always_ff @(posedge ref_clk) begin
    comp_m_r <= comp_in;
    comp_s_r <= comp_m_r;
    res_hi_r <= res_hi_nxt;
    res_lo_r <= res_lo_nxt;
    awaddr_r <= awaddr_nxt;
    wbyte_r  <= wbyte_nxt;
    wstrb0_r <= wstrb0_nxt;
    rdata_r  <= rdata_nxt;
    if (rst) begin
      {aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r} <= 7'h00;
      bresp_r <= RESP_OK;
      rresp_r <= RESP_OK;
      {en_r, ref_r, done_r, intf_r, trigger_source_select_r, align_r, stat_r, mask_r, irq_r, ph_r} <= 10'h000;
      chan_r  <= 4'h0;
      conversion_clock_select_r <= 2'h0;
      st_r    <= ST_IDLE;
      div_r   <= 9'h000;
      cnt_r   <= 5'h00;
      bit_r   <= 4'h0;
      sar_r   <= 10'h000;
      core_r  <= '0;
    end else begin
      {aw_held_r, w_held_r, awready_r, wready_r} <= {aw_held_nxt, w_held_nxt, awready_nxt, wready_nxt};
      {bvalid_r, arready_r, rvalid_r} <= {bvalid_nxt, arready_nxt, rvalid_nxt};
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      {en_r, ref_r, done_r, intf_r, trigger_source_select_r, align_r} <= {en_nxt, ref_nxt, done_nxt, intf_nxt, trigger_source_select_nxt, align_nxt};
      {stat_r, mask_r, irq_r, ph_r} <= {stat_nxt, mask_nxt, irq_nxt, ph_nxt};
      chan_r  <= chan_nxt;
      conversion_clock_select_r <= conversion_clock_select_nxt;
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sar_r   <= sar_nxt;
      core_r  <= core_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign core_ctrl     = core_r;
  assign irq           = irq_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [4:0] tick_seen_r;
  always_ff @(posedge ref_clk) begin
    if (rst || start) tick_seen_r <= 5'h0;
    else if (tick) tick_seen_r <= tick_seen_r + 5'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_conv_length: assert property (finish |-> tick_seen_r == TOTAL_TICKS - 5'h1) // R1
    else $error("conversion not 28 ticks");
  a_done_int: assert property (finish && eff_en |=> done_r && intf_r && stat_r) // R2
    else $error("completion flags missing");
  a_done_busy: assert property (st_r != ST_IDLE |-> !done_r) // R3
    else $error("done set while busy");
  a_done_clear: assert property (!eff_en |=> !done_r) // R4
    else $error("done kept while disabled");
  a_disable_idle: assert property (!eff_en |=> st_r == ST_IDLE && !core_r.enable) // R5
    else $error("ran while disabled");
  a_sw_start: assert property (sw_start && !trigger_source_select_r && eff_en && st_r == ST_IDLE |=> st_r == ST_SETUP) // R6
    else $error("software start lost");
  a_timer_ignored: assert property (!trigger_source_select_r && !sw_start && st_r == ST_IDLE |=> st_r == ST_IDLE) // R7
    else $error("started without trigger");
  a_align_msb: assert property (finish && !align_r |=> res_lo_r[5:0] == 6'h0 && res_hi_r == $past(final_res[9:2])) // R8
    else $error("msb alignment wrong");
  a_int_ack: assert property (int_ack && !finish |=> !intf_r) // R12
    else $error("acknowledge did not clear");

  // slow clocks make a conversion too long for a delay range; the tick counter stands in
  c_full_conv: cover property (finish && tick_seen_r == TOTAL_TICKS - 5'h1);
  c_timer_start: cover property (trigger_source_select_r && timer_match && start);
  c_abort: cover property (st_r == ST_CONVERT ##1 st_r == ST_IDLE && !finish);
endmodule
`default_nettype wire

//--- hdl/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         REF_HZ       = 40_000_000;
  localparam int         CONV_BASE_HZ = 1_000_000;
  localparam logic [8:0] DIV_BASE     = 9'(REF_HZ / CONV_BASE_HZ);
  localparam logic [4:0] SETUP_TICKS  = 5'h2;
  localparam logic [4:0] SAMPLE_TICKS = 5'h6;
  localparam logic [4:0] BIT_TICKS    = 5'h2;
  localparam logic [4:0] RES_BITS     = 5'hA;
  localparam logic [4:0] TOTAL_TICKS  = 5'(SETUP_TICKS + SAMPLE_TICKS + BIT_TICKS * RES_BITS);
  localparam logic [3:0] MSB_INDEX    = 4'h9;
  // ----------------------------------------
  // register indices and byte addresses
  // ----------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [7:0]  IDX_CTRL_LOW  = 8'hCA;
  localparam logic [7:0]  IDX_CTRL_HIGH = 8'hCB;
  localparam logic [7:0]  IDX_RES_LOW   = 8'hCC;
  localparam logic [7:0]  IDX_RES_HIGH  = 8'hCD;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hCE;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hCF;
  localparam logic [11:0] A_CTRL_LOW    = {2'h0, IDX_CTRL_LOW, 2'h0};
  localparam logic [11:0] A_CTRL_HIGH   = {2'h0, IDX_CTRL_HIGH, 2'h0};
  localparam logic [11:0] A_RES_LOW     = {2'h0, IDX_RES_LOW, 2'h0};
  localparam logic [11:0] A_RES_HIGH    = {2'h0, IDX_RES_HIGH, 2'h0};
  localparam logic [11:0] A_IRQ_STAT    = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] A_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int         B_ENABLE = 7;
  localparam int         B_START  = 6;
  localparam int         B_REF    = 5;
  localparam int         B_DONE   = 4;
  localparam int         B_INTF   = 7;
  localparam int         B_TRIGGER_SOURCE_SELECT   = 3;
  localparam int         B_ALIGN  = 2;
  localparam int         B_EVT    = 0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef struct packed {
    logic       enable;
    logic       ref_ext;
    logic [3:0] channel;
    logic       sample;
    logic [9:0] trial;
  } core_ctrl_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SAMPLE, ST_CONVERT} conv_state_t;
endpackage
`default_nettype wire

//--- tb/analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
  import sar_adc_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic                    ref_clk,
  input  wire sar_adc_pkg::core_ctrl_t core_ctrl,
  output logic                         comp_in
);
  // ----------------------------------------
  // input level and comparator
  // ----------------------------------------
  logic [9:0] vin;
  logic [7:0] dly = 8'h00;
  // code and reference pick a level
  assign vin = (10'(core_ctrl.channel) * 10'h05A + 10'h007) >> core_ctrl.ref_ext;
  // slow answer; when disabled the output toggles, never a stale level
  always @(posedge ref_clk) begin
    dly <= {dly[6:0], core_ctrl.enable ? (vin >= core_ctrl.trial) : ~dly[0]};
  end
  assign comp_in = dly[LAT];
endmodule
`default_nettype wire

//--- tb/sar_adc_control_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_unit_bench;
  import sar_adc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              ref_clk;
  logic              rst;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic              stop_mode;
  logic              timer_match;
  logic              int_ack;
  logic              comp_in;
  core_ctrl_t        core_ctrl;
  logic              irq;
  int                errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                hi_cnt = 0;
  int                span = 0;
  int                hi_seen = 0;
  int                span_seen = 0;
  logic              samp_q = 1'b0;
  logic              irq_q = 1'b0;
  logic [1:0]        resp;
  logic [31:0]       rd;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  sar_adc_control_unit dut_u (
    .ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .stop_mode(stop_mode),
    .timer_match(timer_match), .int_ack(int_ack), .comp_in(comp_in),
    .core_ctrl(core_ctrl), .irq(irq)
  );

  analog_core_model model_u (.ref_clk(ref_clk), .core_ctrl(core_ctrl), .comp_in(comp_in));

  // ----------------------------------------
  // timing monitor and timeout
  // ----------------------------------------
  always @(posedge ref_clk) begin
    samp_q <= core_ctrl.sample;
    irq_q <= irq;
    span <= span + 1;
    if (core_ctrl.sample && !samp_q) begin
      hi_cnt <= 1;
      span <= 1;
    end else if (core_ctrl.sample) begin
      hi_cnt <= hi_cnt + 1;
    end
    if (!core_ctrl.sample && samp_q) hi_seen <= hi_cnt;
    if (irq && !irq_q) span_seen <= span;
  end

  // slowest conversion is 8960 cycles; all runs stay far below this
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // bready and rready stay high: the answer is taken when it appears
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask

  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
    rdr(a);
    chk(nm, rd, {24'h0, e});
  endtask

  task automatic conv(input int i);
    logic [3:0] ch;
    logic [9:0] v;
    logic [7:0] hb;
    logic       al;
    logic       rf;
    logic       trg;
    int         t;
    al = i[0];
    rf = i[1];
    trg = (i == 3);
    ch = 4'(3 * i);
    t = 40 << i;
    hb = {4'h0, trg, al, 2'(i)};
    v = (10'(ch) * 10'h05A + 10'h007) >> rf;
    wr(A_CTRL_HIGH, hb);
    // enable first: a start bit only counts once the module is already enabled
    wr(A_CTRL_LOW, {2'b10, rf, 1'b0, ch});
    wr(A_CTRL_LOW, {2'b11, rf, 1'b0, ch});
    rd_chk("ctrl_low_busy", A_CTRL_LOW, {2'b10, rf, trg, ch});
    chk("channel", core_ctrl.channel, ch);
    chk("ref_ext", core_ctrl.ref_ext, rf);
    if (trg) begin
      timer_match <= 1'b1;
      @(posedge ref_clk);
      timer_match <= 1'b0;
    end
    do @(posedge ref_clk); while (irq !== 1'b1);
    @(posedge ref_clk);
    chk("sample_len", hi_seen, 6 * t);
    chk("conv_len", span_seen, 26 * t);
    rd_chk("ctrl_low_done", A_CTRL_LOW, {2'b10, rf, 1'b1, ch});
    rd_chk("int_flag_set", A_CTRL_HIGH, hb | 8'h80);
    rd_chk("res_high", A_RES_HIGH, al ? {6'h0, v[9:8]} : v[9:2]);
    rd_chk("res_low", A_RES_LOW, al ? v[7:0] : {v[1:0], 6'h0});
    wr(A_CTRL_HIGH, hb | 8'h80);
    rd_chk("int_flag_w1", A_CTRL_HIGH, hb | 8'h80);
    if (al) begin
      wr(A_CTRL_HIGH, hb);
    end else begin
      int_ack <= 1'b1;
      @(posedge ref_clk);
      int_ack <= 1'b0;
    end
    rd_chk("int_flag_clr", A_CTRL_HIGH, hb);
    wr(A_IRQ_STAT, 8'h01);
    @(posedge ref_clk);
    chk("irq_clr", irq, 1'b0);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    stop_mode = 1'b0;
    timer_match = 1'b0;
    int_ack = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_chk("ctrl_low_rst", A_CTRL_LOW, 8'h00);
    rd_chk("ctrl_high_rst", A_CTRL_HIGH, 8'h00);
    rdr(12'h400);
    chk("bad_rd_resp", resp, RESP_ERR);
    chk("bad_rd_data", rd, 32'h0);
    wr(12'h400, 8'hFF);
    chk("bad_wr_resp", resp, RESP_ERR);
    wr(A_IRQ_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      conv(i);
    end
    wr(A_CTRL_LOW, 8'h00);
    rd_chk("done_off", A_CTRL_LOW, 8'h00);
    chk("core_off", core_ctrl.enable, 1'b0);
    wr(A_IRQ_MASK, 8'h00);
    wr(A_CTRL_HIGH, 8'h00);
    wr(A_CTRL_LOW, 8'h80);
    // timer strobe under software trigger, watched by the design's assertion
    timer_match <= 1'b1;
    @(posedge ref_clk);
    timer_match <= 1'b0;
    wr(A_CTRL_LOW, 8'hC0);
    do rdr(A_CTRL_LOW); while (rd[4] !== 1'b1);
    rd_chk("stat_masked", A_IRQ_STAT, 8'h01);
    chk("irq_masked", irq, 1'b0);
    wr(A_IRQ_MASK, 8'h01);
    @(posedge ref_clk);
    chk("irq_unmask", irq, 1'b1);
    stop_mode <= 1'b1;
    // done clears at the edge that first sees stop mode
    @(posedge ref_clk);
    rdr(A_CTRL_LOW);
    chk("done_stop", rd[4], 1'b0);
    chk("core_stop", core_ctrl.enable, 1'b0);
    stop_mode <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
